/* File: core/ucl2_ctrl.sv */
// Control-two register block with APB slave, pin ownership, wake and break queuing
//
// The register offsets and register access over APB were chosen for this implementation.
module ucl2_ctrl #(
    parameter int BIT_CYCLES = ucl2_pkg::BIT_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // APB slave
    input wire ucl2_pkg::ucl2_apb_req_s apb_req,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Receive shifter events
    input wire ucl2_pkg::ucl2_rx_evt_s rx_evt,
    output logic rx_serial,
    // Transmit pin
    input wire logic tx_pin_in,
    output logic tx_pin_out,
    output logic tx_pin_oe_n,
    // Receive pin
    input wire logic rx_pin_in,
    output logic rx_pin_owned,
    // Interrupt request
    output logic irq
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [7:0] ctrl2;
    logic [7:0] cfg;
    logic [7:0] tx_buf;
    logic [7:0] rx_buf;
    logic tx_buffer_empty_flag;
    logic tc;
    logic rx_buffer_full_flag;
    logic idle_flag;
    logic brk_pend;
    logic idle_pend;
    logic start_r;
    ucl2_pkg::ucl2_kind_e kind_r;
    logic tx_busy;
    logic tx_line;
    logic tx_owned;
    logic tx_sync1;
    logic tx_sync2;
    logic rx_sync1;
    logic rx_sync2;
    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    logic wr_ctrl2;
    logic wr_cfg;
    logic wr_status;
    logic wr_data;
    logic rd_data;
    logic te_rise;
    logic sbk_rise;
    logic can_issue;
    logic issue;
    logic wake_hit;
    logic single_wire;
    logic loopback;
    logic [7:0] next_ctrl2;
    logic [31:0] next_rdata;

    // ************************************************************
    // APB decode
    // ************************************************************
    // Access phase always completes on its first cycle; pready is a flop
    assign acc = apb_req.psel && apb_req.penable && pready;
    assign wr = acc && apb_req.pwrite;
    assign rd = acc && !apb_req.pwrite;
    assign mapped = (apb_req.paddr == ucl2_pkg::OFS_CTRL2) ||
                    (apb_req.paddr == ucl2_pkg::OFS_CONFIG) ||
                    (apb_req.paddr == ucl2_pkg::OFS_STATUS) ||
                    (apb_req.paddr == ucl2_pkg::OFS_DATA);
    assign wr_ctrl2 = wr && (apb_req.paddr == ucl2_pkg::OFS_CTRL2);
    assign wr_cfg = wr && (apb_req.paddr == ucl2_pkg::OFS_CONFIG);
    assign wr_status = wr && (apb_req.paddr == ucl2_pkg::OFS_STATUS);
    assign wr_data = wr && (apb_req.paddr == ucl2_pkg::OFS_DATA);
    assign rd_data = rd && (apb_req.paddr == ucl2_pkg::OFS_DATA);

    assign loopback = cfg[ucl2_pkg::B_LOOPBACK];
    assign single_wire = loopback && cfg[ucl2_pkg::B_RX_SOURCE];

    // Read mux, sampled in the setup cycle so prdata is a flop
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (apb_req.paddr)
            ucl2_pkg::OFS_CTRL2: next_rdata[7:0] = ctrl2;
            ucl2_pkg::OFS_CONFIG: next_rdata[7:0] = cfg;
            ucl2_pkg::OFS_STATUS: begin
                next_rdata[ucl2_pkg::B_ST_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag;
                next_rdata[ucl2_pkg::B_ST_TC] = tc;
                next_rdata[ucl2_pkg::B_ST_RX_BUFFER_FULL_FLAG] = rx_buffer_full_flag;
                next_rdata[ucl2_pkg::B_ST_IDLE] = idle_flag;
                next_rdata[ucl2_pkg::B_ST_BUSY] = tx_busy;
            end
            ucl2_pkg::OFS_DATA: next_rdata[7:0] = rx_buf;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Bus answer: ready and error arrive with the access phase
    always_ff @(posedge clk) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= apb_req.psel && !apb_req.penable;
            pslverr <= apb_req.psel && !apb_req.penable && !mapped;
            if (apb_req.psel && !apb_req.penable) begin
                prdata <= next_rdata;
            end
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    assign te_rise = wr_ctrl2 && apb_req.pwdata[ucl2_pkg::B_TX_EN] && !ctrl2[ucl2_pkg::B_TX_EN];
    assign sbk_rise = wr_ctrl2 && apb_req.pwdata[ucl2_pkg::B_BREAK] && !ctrl2[ucl2_pkg::B_BREAK];

    // Wake condition seen while in standby
    always_comb begin
        wake_hit = 1'b0;
        if (ctrl2[ucl2_pkg::B_WAKE_CTRL]) begin
            if (cfg[ucl2_pkg::B_WAKE_SEL]) begin
                wake_hit = rx_evt.char_valid && rx_evt.char_msb;
            end else begin
                wake_hit = rx_evt.idle_det;
            end
        end
    end

    // A software write of the wake bit wins over the hardware clear
    always_comb begin
        next_ctrl2 = ctrl2;
        if (wake_hit) begin
            next_ctrl2[ucl2_pkg::B_WAKE_CTRL] = 1'b0;
        end
        if (wr_ctrl2) begin
            next_ctrl2 = apb_req.pwdata[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl2 <= ucl2_pkg::CTRL2_RESET;
        end else begin
            ctrl2 <= next_ctrl2;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cfg <= ucl2_pkg::CONFIG_RESET;
        end else if (wr_cfg) begin
            cfg <= apb_req.pwdata[7:0];
        end
    end

    // ************************************************************
    // Transmit queue
    // ************************************************************
    // Break beats idle beats data; one start in flight at a time
    assign can_issue = !tx_busy && !start_r;
    assign issue = can_issue && (brk_pend || idle_pend || !tx_buffer_empty_flag);

    // Pending break: a rising write queues one, a held bit keeps requeuing.
    // The held-bit test is sampled while the shifter is free, so a clear that
    // lands just after a frame ends can still see a second break go out.
    always_ff @(posedge clk) begin
        if (reset) begin
            brk_pend <= 1'b0;
        end else if (sbk_rise || (ctrl2[ucl2_pkg::B_BREAK] && can_issue && !brk_pend)) begin
            brk_pend <= 1'b1;
        end else if (issue && brk_pend) begin
            brk_pend <= 1'b0;
        end
    end

    // Re-enabling the transmitter queues one idle character
    always_ff @(posedge clk) begin
        if (reset) begin
            idle_pend <= 1'b0;
        end else if (te_rise) begin
            idle_pend <= 1'b1;
        end else if (issue && !brk_pend && idle_pend) begin
            idle_pend <= 1'b0;
        end
    end

    // Start pulse and frame kind for the shifter
    always_ff @(posedge clk) begin
        if (reset) begin
            start_r <= 1'b0;
            kind_r <= ucl2_pkg::UCL2_KIND_IDLE;
        end else begin
            start_r <= issue;
            if (issue) begin
                if (brk_pend) begin
                    kind_r <= ucl2_pkg::UCL2_KIND_BREAK;
                end else if (idle_pend) begin
                    kind_r <= ucl2_pkg::UCL2_KIND_IDLE;
                end else begin
                    kind_r <= ucl2_pkg::UCL2_KIND_DATA;
                end
            end
        end
    end

    // Transmit buffer; moving into the shifter frees it, set wins over write
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_buffer_empty_flag <= 1'b1;
            tx_buf <= 8'h00;
        end else begin
            if (wr_data) begin
                tx_buf <= apb_req.pwdata[7:0];
            end
            if (issue && !brk_pend && !idle_pend) begin
                tx_buffer_empty_flag <= 1'b1;
            end else if (wr_data) begin
                tx_buffer_empty_flag <= 1'b0;
            end
        end
    end

    // Complete once the buffer is empty and nothing is sent or queued
    always_ff @(posedge clk) begin
        if (reset) begin
            tc <= 1'b1;
        end else begin
            tc <= tx_buffer_empty_flag && !wr_data && !tx_busy && !start_r && !brk_pend && !idle_pend &&
                  !te_rise && !sbk_rise;
        end
    end

    ucl2_tx_shift #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_tx (
        .clk(clk),
        .reset(reset),
        .start(start_r),
        .kind(kind_r),
        .data(tx_buf),
        .long_break(cfg[ucl2_pkg::B_LONG_BREAK]),
        .busy(tx_busy),
        .line(tx_line)
    );

    // ************************************************************
    // Receive flags
    // ************************************************************
    // Standby hides traffic; an address mark that wakes is itself received
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_buffer_full_flag <= 1'b0;
            rx_buf <= 8'h00;
        end else if (rx_evt.char_valid && ctrl2[ucl2_pkg::B_RX_EN] &&
                     (!ctrl2[ucl2_pkg::B_WAKE_CTRL] || wake_hit)) begin
            rx_buffer_full_flag <= 1'b1;
            rx_buf <= rx_evt.char_data;
        end else if (rd_data) begin
            rx_buffer_full_flag <= 1'b0;
        end
    end

    // Idle flag, cleared by writing one to its status bit; set wins
    always_ff @(posedge clk) begin
        if (reset) begin
            idle_flag <= 1'b0;
        end else if (rx_evt.idle_det && ctrl2[ucl2_pkg::B_RX_EN] &&
                     !ctrl2[ucl2_pkg::B_WAKE_CTRL]) begin
            idle_flag <= 1'b1;
        end else if (wr_status && apb_req.pwdata[ucl2_pkg::B_ST_IDLE]) begin
            idle_flag <= 1'b0;
        end
    end

    // ************************************************************
    // Interrupt request
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= (ctrl2[ucl2_pkg::B_TX_EMPTY_IE] && tx_buffer_empty_flag) ||
                   (ctrl2[ucl2_pkg::B_TX_DONE_IE] && tc) ||
                   (ctrl2[ucl2_pkg::B_RX_FULL_IE] && rx_buffer_full_flag) ||
                   (ctrl2[ucl2_pkg::B_IDLE_IE] && idle_flag);
        end
    end

    // ************************************************************
    // Pins
    // ************************************************************
    // Pins come from outside the clock domain: two flops before any use
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_sync1 <= 1'b1;
            tx_sync2 <= 1'b1;
            rx_sync1 <= 1'b1;
            rx_sync2 <= 1'b1;
        end else begin
            tx_sync1 <= tx_pin_in;
            tx_sync2 <= tx_sync1;
            rx_sync1 <= rx_pin_in;
            rx_sync2 <= rx_sync1;
        end
    end

    // Ownership outlives the enable until every queued frame has gone
    assign tx_owned = ctrl2[ucl2_pkg::B_TX_EN] || tx_busy || start_r ||
                      brk_pend || idle_pend || !tx_buffer_empty_flag;

    // Single-wire mode drives the line only when the direction bit says out
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_pin_out <= 1'b1;
            tx_pin_oe_n <= 1'b1;
        end else begin
            tx_pin_out <= tx_line;
            tx_pin_oe_n <= !(tx_owned && (!single_wire || cfg[ucl2_pkg::B_SW_DIR]));
        end
    end

    // Receiver input: internal loop, shared wire, or the receive pin
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_serial <= 1'b1;
            rx_pin_owned <= 1'b0;
        end else begin
            if (single_wire) begin
                rx_serial <= tx_sync2;
            end else if (loopback) begin
                rx_serial <= tx_line;
            end else begin
                rx_serial <= rx_sync2;
            end
            rx_pin_owned <= ctrl2[ucl2_pkg::B_RX_EN] && !loopback;
        end
    end

endmodule

/* File: core/ucl2_tx_shift.sv */
// Transmit shifter that sends data, idle or break frames at one bit per tick
module ucl2_tx_shift #(
    parameter int BIT_CYCLES = ucl2_pkg::BIT_CYCLES_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Frame request
    input wire logic start,
    input wire ucl2_pkg::ucl2_kind_e kind,
    input wire logic [7:0] data,
    input wire logic long_break,
    // Line side
    output logic busy,
    output logic line
);

    typedef enum logic {
        UCL2_TX_IDLE = 1'b0,
        UCL2_TX_SHIFT = 1'b1
    } ucl2_tx_state_e;

    generate
        if (BIT_CYCLES < 1) begin : g_bad_bit_cycles
            $error("BIT_CYCLES must be at least one");
        end
    endgenerate

    localparam int DIV_W = (BIT_CYCLES > 1) ? $clog2(BIT_CYCLES) : 1;
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_CYCLES - 1);

    ucl2_tx_state_e state;
    logic [DIV_W-1:0] div_cnt;
    logic [3:0] bits_left;
    logic [ucl2_pkg::SHIFT_W-1:0] shreg;
    logic [ucl2_pkg::SHIFT_W-1:0] next_frame;
    logic [3:0] next_len;

    // Frame image, lsb goes out first; idle bits pad the top
    always_comb begin
        next_frame = '1;
        next_len = 4'(ucl2_pkg::FRAME_BITS);
        unique case (kind)
            ucl2_pkg::UCL2_KIND_DATA: next_frame[ucl2_pkg::FRAME_BITS-1:0] = {1'b1, data, 1'b0};
            ucl2_pkg::UCL2_KIND_IDLE: next_frame = '1;
            ucl2_pkg::UCL2_KIND_BREAK: begin
                next_frame = '0;
                next_len = long_break ? 4'(ucl2_pkg::LONG_BREAK_BITS) : 4'(ucl2_pkg::BREAK_BITS);
            end
            default: next_frame = '1;
        endcase
    end

    // Frame sequencer
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= UCL2_TX_IDLE;
            div_cnt <= '0;
            bits_left <= 4'h0;
            shreg <= '1;
        end else begin
            unique case (state)
                UCL2_TX_IDLE: begin
                    if (start) begin
                        state <= UCL2_TX_SHIFT;
                        shreg <= next_frame;
                        bits_left <= next_len;
                        div_cnt <= '0;
                    end
                end
                UCL2_TX_SHIFT: begin
                    if (div_cnt == DIV_LAST) begin
                        div_cnt <= '0;
                        shreg <= {1'b1, shreg[ucl2_pkg::SHIFT_W-1:1]};
                        bits_left <= bits_left - 4'h1;
                        if (bits_left == 4'h1) begin
                            state <= UCL2_TX_IDLE;
                        end
                    end else begin
                        div_cnt <= div_cnt + DIV_W'(1);
                    end
                end
            endcase
        end
    end

    // Line rests high between frames so a release leaves the mark level
    always_ff @(posedge clk) begin
        if (reset) begin
            line <= 1'b1;
            busy <= 1'b0;
        end else begin
            line <= (state == UCL2_TX_SHIFT) ? shreg[0] : 1'b1;
            busy <= (state == UCL2_TX_SHIFT) || start;
        end
    end

endmodule

/* File: shared/ucl2_pkg.sv */
// Constants, types and register map of the serial control-two block
// Functional notes
// - Control-two register reads and writes at any time; every bit resets to zero.
// - Bit 7 set routes the transmit-buffer-empty flag onto the interrupt request.
// - Bit 6 set routes the transmission-complete flag onto the interrupt request.
// - Bit 5 set routes the receive-buffer-full flag onto the interrupt request.
// - Bit 4 set routes the idle-line flag onto the interrupt request.
// - Bit 3 enables the transmitter and makes the block own the transmit pin.
// - In single-wire mode the direction bit sets the shared line direction.
// - Turning the transmitter enable off then on queues one idle character.
// - After disable the transmit pin stays owned until queued work finishes.
// - Bit 2 enables the receiver; when off the receive pin is released.
// - Loopback always releases the receive pin, whatever the receiver enable.
// - Bit 1 set puts the receiver in standby awaiting the wake condition.
// - Wake on idle line with wake select 0, on data msb high with 1.
// - Hardware clears the wake control bit when the wake condition is seen.
// - Writing 0 then 1 to bit 0 queues one all-zero break character.
// - Breaks repeat while bit 0 stays set; 10 bit times, 13 with long option.
// - A second break may be queued before software clears the send-break bit.
// - Loopback with receiver source select joins transmit pin to receiver input.
// - Transmit-empty flag is set at reset and when a character enters the shifter.
// - Complete flag is set at reset and when idle with nothing queued or sending.
package ucl2_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] OFS_CTRL2 = 8'h00;
    localparam logic [7:0] OFS_CONFIG = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_DATA = 8'h0C;
    localparam logic [7:0] CTRL2_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int B_TX_EMPTY_IE = 7;
    localparam int B_TX_DONE_IE = 6;
    localparam int B_RX_FULL_IE = 5;
    localparam int B_IDLE_IE = 4;
    localparam int B_TX_EN = 3;
    localparam int B_RX_EN = 2;
    localparam int B_WAKE_CTRL = 1;
    localparam int B_BREAK = 0;
    localparam int B_LONG_BREAK = 0;
    localparam int B_WAKE_SEL = 1;
    localparam int B_LOOPBACK = 2;
    localparam int B_RX_SOURCE = 3;
    localparam int B_SW_DIR = 4;
    localparam int B_ST_TX_BUFFER_EMPTY_FLAG = 7;
    localparam int B_ST_TC = 6;
    localparam int B_ST_RX_BUFFER_FULL_FLAG = 5;
    localparam int B_ST_IDLE = 4;
    localparam int B_ST_BUSY = 0;

    // ************************************************************
    // Frame shapes and timing
    // ************************************************************
    localparam int FRAME_BITS = 10;
    localparam int BREAK_BITS = 10;
    localparam int LONG_BREAK_BITS = 13;
    localparam int SHIFT_W = 13;
    localparam int BIT_CYCLES_DEF = 16;

    typedef enum logic [1:0] {
        UCL2_KIND_DATA = 2'b00,
        UCL2_KIND_IDLE = 2'b01,
        UCL2_KIND_BREAK = 2'b10
    } ucl2_kind_e;

    // APB request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } ucl2_apb_req_s;

    // Events from the receive shifter on the same clock
    typedef struct packed {
        logic char_valid;
        logic char_msb;
        logic [7:0] char_data;
        logic idle_det;
    } ucl2_rx_evt_s;

endpackage

/* File: verif/tb_uart_control_two_logic.sv */
// Testbench for the control-two block
module tb_uart_control_two_logic;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int BC = 2;
    localparam logic [7:0] CTL = ucl2_pkg::OFS_CTRL2;
    localparam logic [7:0] CFG = ucl2_pkg::OFS_CONFIG;
    localparam logic [7:0] STA = ucl2_pkg::OFS_STATUS;
    localparam logic [7:0] DAT = ucl2_pkg::OFS_DATA;
    logic clk = 1'h0;
    logic reset;
    ucl2_pkg::ucl2_apb_req_s apb_req;
    ucl2_pkg::ucl2_rx_evt_s rx_evt;
    logic [31:0] prdata, q;
    logic pready, pslverr, err, rx_serial, tx_pin_out, tx_pin_oe_n, rx_pin_in;
    logic rx_pin_owned, irq, tx_wire;
    logic [10:0] ev [3] = '{11'h001, 11'h402, 11'h700};
    int num_errors = 0, comparisons = 0, low_run, n, i;
    // Pull-up on the transmit wire while nobody drives it
    assign tx_wire = tx_pin_oe_n ? 1'h1 : tx_pin_out;
    always #12.5 clk = ~clk;
    ucl2_ctrl #(.BIT_CYCLES(BC)) dut_u (.clk(clk), .reset(reset), .apb_req(apb_req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_evt(rx_evt),
        .rx_serial(rx_serial), .tx_pin_in(tx_wire), .tx_pin_out(tx_pin_out),
        .tx_pin_oe_n(tx_pin_oe_n), .rx_pin_in(rx_pin_in), .rx_pin_owned(rx_pin_owned),
        .irq(irq));
    ucl2_serial_peer peer_u (.clk(clk), .tx_wire(tx_wire), .rx_line(rx_pin_in),
        .low_run(low_run));
    // ****************************************
    // Bus and check tasks
    // ****************************************
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        apb_req <= {1'h1, 1'h0, w, a, d};
        @(posedge clk);
        apb_req.penable <= 1'h1;
        // Wait for the answer; only the watchdog ends a stuck transfer
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        q = prdata;
        err = pslverr;
        apb_req <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a);
        apb(1'h0, a, 32'h0);
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // One-cycle receive event, then let the flags settle
    task automatic pulse(input logic [10:0] v);
        @(posedge clk);
        rx_evt <= v;
        @(posedge clk);
        rx_evt <= '0;
        repeat (2) @(posedge clk);
    endtask
    task automatic wait_tc;
        i = 0;
        do begin
            rd(STA);
            i++;
        end while (q[6] !== 1'h1 && i < 200);
        chk("tc", 32'h1, q[6]);
        repeat (2) @(posedge clk);
    endtask
    task automatic test_done;
        $display("errors=%0d comparisons=%0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        reset = 1'h1;
        apb_req = '0;
        rx_evt = '0;
        repeat (10) @(posedge clk);
        reset <= 1'h0;
        rd(CTL); chk("ctrl2", 32'h0, q);
        rd(STA); chk("status", 32'hC0, q);
        rd(8'h10); chk("slverr", 32'h1, err);
        wr(CTL, 32'hF4); rd(CTL); chk("ctrl2", 32'hF4, q);
        // Buffer and complete flags are set, receive flags clear
        for (int b = 4; b < 8; b++) begin
            wr(CTL, 32'h1 << b);
            repeat (2) @(posedge clk);
            chk("irq", b >= 6, irq);
        end
        wr(CTL, 32'h24); pulse(11'h700); chk("irq", 32'h1, irq);
        rd(DAT); chk("rx_data", 32'h80, q);
        repeat (2) @(posedge clk); chk("irq", 32'h0, irq);
        wr(CTL, 32'h14); pulse(11'h001); chk("irq", 32'h1, irq);
        wr(STA, 32'h10); repeat (2) @(posedge clk); chk("irq", 32'h0, irq);
        // Idle wake, msb-low char that must not wake, msb-high char
        for (int k = 0; k < 3; k++) begin
            wr(CFG, k == 0 ? 32'h0 : 32'h2);
            wr(CTL, 32'h06);
            pulse(ev[k]);
            rd(CTL); chk("wake", k == 1 ? 32'h06 : 32'h04, q);
        end
        chk("rx_owned", 32'h1, rx_pin_owned);
        wr(CFG, 32'h04); repeat (2) @(posedge clk);
        chk("rx_owned", 32'h0, rx_pin_owned);
        wr(CFG, 32'h0);
        wr(CTL, 32'h08); repeat (3) @(posedge clk);
        rd(STA); chk("busy", 32'h1, q[0]);
        chk("tx_oe_n", 32'h0, tx_pin_oe_n);
        // First break is queued behind the idle frame, the long one on a free line
        for (int k = 0; k < 2; k++) begin
            wr(CFG, k);
            wr(CTL, 32'h09);
            wr(CTL, 32'h08);
            wait_tc();
            chk("break_len", (k ? 13 : 10) * BC, low_run);
        end
        for (int k = 0; k < 2; k++) begin
            wr(CFG, 32'h0C | (k << 4)); repeat (3) @(posedge clk);
            chk("sw_oe_n", !k, tx_pin_oe_n);
        end
        // A break on the shared wire must come back on the receive stream
        wr(CTL, 32'h09); wr(CTL, 32'h08); repeat (8) @(posedge clk);
        chk("rx_serial", 32'h0, rx_serial);
        wait_tc();
        wr(CFG, 32'h0);
        wr(DAT, 32'h55); wr(CTL, 32'h0);
        n = 0;
        while (tx_pin_oe_n !== 1'h1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        chk("tx_release", 32'h1, tx_pin_oe_n);
        chk("tx_hold", 32'h1, n >= ucl2_pkg::FRAME_BITS * BC);
        chk("tx_idle", 32'h1, tx_pin_out);
        test_done();
    end
    // Watchdog well beyond the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end
endmodule

/* File: verif/ucl2_ctrl_sva.sv */
// Assertion checker on the control-two block ports
module ucl2_ctrl_sva (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Observed ports
    input wire ucl2_pkg::ucl2_apb_req_s apb_req,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tx_pin_out,
    input wire logic tx_pin_oe_n,
    input wire logic rx_pin_owned,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // Shadow of written control and config
    // ****************************************
    logic [7:0] ctl;
    logic [7:0] cfg;
    logic wr;
    assign wr = apb_req.psel && apb_req.penable && pready && apb_req.pwrite;
    // Wake bit is cleared by hardware, so bit 1 of the shadow is never used
    always_ff @(posedge clk) begin
        if (reset) begin
            ctl <= 8'h00;
            cfg <= 8'h00;
        end else if (wr && apb_req.paddr == ucl2_pkg::OFS_CTRL2) begin
            ctl <= apb_req.pwdata[7:0];
        end else if (wr && apb_req.paddr == ucl2_pkg::OFS_CONFIG) begin
            cfg <= apb_req.pwdata[7:0];
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_reset_idle: assert property (
        $fell(reset) |-> !irq && tx_pin_oe_n && tx_pin_out && !rx_pin_owned)
        else $error("outputs not idle after reset");
    a_ready_next: assert property (
        apb_req.psel && !apb_req.penable |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_irq_masked: assert property ((ctl[7:4] == 4'h0) [*2] |-> !irq)
        else $error("irq with all enables clear");
    a_rx_off_free: assert property ((!ctl[2]) [*2] |-> !rx_pin_owned)
        else $error("receive pin held while receiver off");
    a_loop_rx_free: assert property (cfg[2] [*2] |-> !rx_pin_owned)
        else $error("receive pin held in loopback");
    a_tx_owned: assert property ((ctl[3] && !cfg[2]) [*2] |-> !tx_pin_oe_n)
        else $error("transmit pin not driven while enabled");
    a_sw_listen: assert property ((cfg[4:2] == 3'h3) [*2] |-> tx_pin_oe_n)
        else $error("shared line driven while direction is input");
    a_release_high: assert property ($rose(tx_pin_oe_n) |-> $past(tx_pin_out))
        else $error("transmit pin released while low");
endmodule
bind ucl2_ctrl ucl2_ctrl_sva chk_u (.clk(clk), .reset(reset), .apb_req(apb_req),
    .pready(pready), .pslverr(pslverr), .tx_pin_out(tx_pin_out),
    .tx_pin_oe_n(tx_pin_oe_n), .rx_pin_owned(rx_pin_owned), .irq(irq));

/* File: verif/ucl2_serial_peer.sv */
// Remote serial partner: idles its line and times low runs on the transmit wire
module ucl2_serial_peer (
    // Clock
    input wire logic clk,
    // Serial lines
    input wire logic tx_wire,
    output logic rx_line,
    // Clocks in the last finished low run
    output int low_run
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt = 0;
    // An idle remote transmitter holds the stop level
    initial rx_line = 1'b1;
    initial low_run = 0;
    // Break length is the span of one unbroken low run
    always @(posedge clk) begin
        if (!tx_wire) begin
            cnt <= cnt + 1;
        end else if (cnt != 0) begin
            low_run <= cnt;
            cnt <= 0;
        end
    end
endmodule
